// >>> verilog/bcl_pkg.sv
// Constants and carrier types of the buck regulator control logic
package bcl_pkg;
  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned FSW_HZ = 1_000_000;
  localparam int unsigned DEAD_TIME_NS = 80;
  localparam int unsigned DEAD_CYC = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SS_LONG_MS = 8;
  localparam int unsigned SS_SHORT_MS = 4;
  localparam int unsigned RETRY_MS = 15;
  localparam int unsigned DITHER_PERIOD_US = 256;
  localparam int unsigned SS_LONG_CYC = SS_LONG_MS * (CLK_HZ / 1000);
  localparam int unsigned SS_SHORT_CYC = SS_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned RETRY_CYC = RETRY_MS * (CLK_HZ / 1000);
  localparam int unsigned DITHER_PERIOD_CYC = DITHER_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned ACC_W = 16;
  localparam int unsigned STEP_NOM = 32'((64'h1 << ACC_W) * FSW_HZ / CLK_HZ);
  localparam int unsigned DITHER_PCT = 6;
  localparam int unsigned STEP_DEV = STEP_NOM * DITHER_PCT / 100;
  localparam int unsigned RAMP_STEPS = 256;
  localparam logic [3:0] HICCUP_LIMIT = 4'hf;
  localparam logic [7:0] RAMP_TOP = 8'hff;
  // ******************************************************************
  // Register map
  // ******************************************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int unsigned CTRL_SW_EN = 0;
  localparam int unsigned CTRL_EN_AND = 1;
  localparam int unsigned CTRL_RAMP = 2;
  localparam int unsigned CTRL_DITHER = 3;
  localparam int unsigned CTRL_PEAK = 4;
  localparam int unsigned STAT_MODE = 0;
  localparam int unsigned STAT_GOOD = 3;
  localparam int unsigned STAT_PIN = 4;
  localparam int unsigned STAT_STRAP = 5;
  localparam int unsigned STAT_EN = 6;
  localparam int unsigned STAT_MUX_A = 7;
  localparam int unsigned STAT_MUX_B = 8;
  localparam int unsigned STAT_HICCUP = 9;
  localparam int unsigned STAT_PHASE = 13;
  localparam int unsigned STAT_RAMP = 16;
  localparam logic [1:0] PEAK_CODE_RST = 2'h0;
  localparam logic [1:0] PEAK_CODE_STRAP = 2'h3;
  // ******************************************************************
  // Types
  // ******************************************************************
  typedef enum logic [2:0] {
    BCL_OFF = 3'h0, BCL_SOFTSTART = 3'h1, BCL_RUN = 3'h2,
    BCL_STANDBY = 3'h3, BCL_HICCUP = 3'h4
  } bcl_mode_t;
  typedef enum logic [2:0] {
    BCL_SW_IDLE = 3'h0, BCL_SW_HIGH = 3'h1, BCL_SW_DEAD_HL = 3'h2,
    BCL_SW_LOW = 3'h3, BCL_SW_DEAD_LH = 3'h4
  } bcl_phase_t;
  typedef struct packed {
    logic hw_enable;
    logic peak_limit_strap;
    logic fixed_high_vout;
    logic uvlo;
    logic interface_rail_valid;
    logic thermal_shdn;
    logic pwm_trip;
    logic peak_trip;
    logic below_zero_cross;
    logic below_valley;
    logic above_92;
    logic below_90;
    logic below_99;
    logic below_25;
    logic in_regulation;
    logic light_load;
    logic mux_a_over_b;
    logic mux_b_over_a;
    logic output_good_pin;
  } bcl_sense_t;
  typedef struct packed {
    logic sw_enable;
    logic en_and;
    logic ramp_time_select;
    logic freq_dither_select;
    logic [1:0] peak_code;
  } bcl_cfg_t;
  localparam bcl_cfg_t CFG_RST = '{peak_code: PEAK_CODE_RST, default: 1'b0};
  typedef struct packed {
    bcl_sense_t sync1;
    bcl_sense_t sync2;
    bcl_cfg_t cfg;
    bcl_mode_t mode;
    bcl_phase_t phase;
    logic [1:0] dead_cnt;
    logic [3:0] hiccup_cnt;
    logic [19:0] tmr;
    logic [7:0] ramp;
    logic [15:0] acc;
    logic [12:0] tri_cnt;
    logic tri_down;
    logic en;
    logic mux_a_on;
    logic mux_b_on;
    logic good;
    logic good_oe;
    logic [1:0] peak_lim;
    logic hs;
    logic ls;
    logic hiz;
    logic standby;
    logic bias_ldo;
    logic bias_to_out;
    logic wait_req;
    logic [31:0] rdata;
  } bcl_state_t;
  localparam bcl_state_t ST_RST = '{
    cfg: CFG_RST, mode: BCL_OFF, phase: BCL_SW_IDLE, hiz: 1'b1, wait_req: 1'b1,
    good_oe: 1'b1, default: '0
  };
endpackage : bcl_pkg

// >>> verilog/bcl_ctrl.sv
// Buck regulator control and sequencing logic with Avalon-MM registers
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module bcl_ctrl #(
  parameter int unsigned SS_LONG_CYCLES = bcl_pkg::SS_LONG_CYC,
  parameter int unsigned SS_SHORT_CYCLES = bcl_pkg::SS_SHORT_CYC,
  parameter int unsigned RETRY_CYCLES = bcl_pkg::RETRY_CYC,
  parameter int unsigned DITHER_CYCLES = bcl_pkg::DITHER_PERIOD_CYC
) (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic [3:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  input wire bcl_pkg::bcl_sense_t SENSE_IN,
  output logic HIGH_SIDE_SWITCH_OUT,
  output logic LOW_SIDE_SWITCH_OUT,
  output logic SWITCH_NODE_HIZ_OUT,
  output logic STANDBY_OUT,
  output logic [1:0] PEAK_CURRENT_LIMIT_OUT,
  output logic [7:0] RAMP_LEVEL_OUT,
  output logic OUTPUT_GOOD_OUT,
  output logic OUTPUT_GOOD_OE_OUT,
  output logic BIAS_LDO_ON_OUT,
  output logic BIAS_TO_OUTPUT_OUT,
  output logic MUX_INPUT_A_ON_OUT,
  output logic MUX_INPUT_B_ON_OUT
);
  // ******************************************************************
  // Derived counts
  // ******************************************************************
  localparam int unsigned SS_LONG_STEP = SS_LONG_CYCLES / bcl_pkg::RAMP_STEPS;
  localparam int unsigned SS_SHORT_STEP = SS_SHORT_CYCLES / bcl_pkg::RAMP_STEPS;
  localparam int unsigned TRI_HALF = DITHER_CYCLES / 2;
  localparam logic [19:0] SS_LONG_LAST = 20'(SS_LONG_STEP - 1);
  localparam logic [19:0] SS_SHORT_LAST = 20'(SS_SHORT_STEP - 1);
  localparam logic [19:0] RETRY_LAST = 20'(RETRY_CYCLES - 1);
  localparam logic [12:0] TRI_TOP = 13'(TRI_HALF);
  localparam logic [1:0] DEAD_LAST = 2'(bcl_pkg::DEAD_CYC - 1);

  bcl_pkg::bcl_state_t st;
  bcl_pkg::bcl_state_t next_st;

  // ******************************************************************
  // Helpers
  // ******************************************************************
  // Phase step: swept linearly from -6% to +6% of nominal
  function automatic logic [15:0] dither_step(input logic [12:0] tri_pos);
    int unsigned span;
    span = (32'(tri_pos) * 2 * bcl_pkg::STEP_DEV) / TRI_HALF;
    return 16'(bcl_pkg::STEP_NOM - bcl_pkg::STEP_DEV + span);
  endfunction : dither_step

  function automatic logic [31:0] reg_read(input logic [3:0] addr,
                                           input bcl_pkg::bcl_state_t s);
    logic [31:0] d;
    d = 32'h0;
    if (addr == bcl_pkg::REG_CTRL) begin
      d[bcl_pkg::CTRL_SW_EN] = s.cfg.sw_enable;
      d[bcl_pkg::CTRL_EN_AND] = s.cfg.en_and;
      d[bcl_pkg::CTRL_RAMP] = s.cfg.ramp_time_select;
      d[bcl_pkg::CTRL_DITHER] = s.cfg.freq_dither_select;
      d[bcl_pkg::CTRL_PEAK +: 2] = s.cfg.peak_code;
    end else if (addr == bcl_pkg::REG_STATUS) begin
      d[bcl_pkg::STAT_MODE +: 3] = s.mode;
      d[bcl_pkg::STAT_GOOD] = s.good;
      d[bcl_pkg::STAT_PIN] = s.sync2.output_good_pin;
      d[bcl_pkg::STAT_STRAP] = s.sync2.peak_limit_strap;
      d[bcl_pkg::STAT_EN] = s.en;
      d[bcl_pkg::STAT_MUX_A] = s.mux_a_on;
      d[bcl_pkg::STAT_MUX_B] = s.mux_b_on;
      d[bcl_pkg::STAT_HICCUP +: 4] = s.hiccup_cnt;
      d[bcl_pkg::STAT_PHASE +: 3] = s.phase;
      d[bcl_pkg::STAT_RAMP +: 8] = s.ramp;
    end
    return d;
  endfunction : reg_read

  // ******************************************************************
  // Next state
  // ******************************************************************
  always_comb begin
    bcl_pkg::bcl_sense_t s;
    logic active;
    logic switching;
    logic tick;
    logic start_ok;
    logic on_end;
    logic hiccup_trip;
    logic [15:0] step;
    logic [19:0] ss_last;
    next_st = st;
    s = st.sync2;
    active = 1'b0;
    switching = 1'b0;
    tick = 1'b0;
    start_ok = 1'b0;
    on_end = 1'b0;
    hiccup_trip = 1'b0;
    step = 16'(bcl_pkg::STEP_NOM);
    ss_last = SS_LONG_LAST;

    // Analog sense and pins cross into the clock domain
    next_st.sync1 = SENSE_IN;
    next_st.sync2 = st.sync1;

    // Register bus: one wait cycle, then answer
    next_st.wait_req = 1'b1;
    if ((AVS_READ_IN || AVS_WRITE_IN) && st.wait_req) begin
      next_st.wait_req = 1'b0;
      next_st.rdata = reg_read(AVS_ADDRESS_IN, st);
    end
    if (AVS_WRITE_IN && !st.wait_req && AVS_ADDRESS_IN == bcl_pkg::REG_CTRL
        && AVS_BYTEENABLE_IN[0]) begin
      next_st.cfg.sw_enable = AVS_WRITEDATA_IN[bcl_pkg::CTRL_SW_EN];
      next_st.cfg.en_and = AVS_WRITEDATA_IN[bcl_pkg::CTRL_EN_AND];
      next_st.cfg.ramp_time_select = AVS_WRITEDATA_IN[bcl_pkg::CTRL_RAMP];
      next_st.cfg.freq_dither_select = AVS_WRITEDATA_IN[bcl_pkg::CTRL_DITHER];
      // Code writes only land while the strap is low
      if (!s.peak_limit_strap) begin
        next_st.cfg.peak_code = AVS_WRITEDATA_IN[bcl_pkg::CTRL_PEAK +: 2];
      end
    end
    if (s.uvlo || !s.interface_rail_valid) begin
      next_st.cfg = bcl_pkg::CFG_RST;
    end
    // Strap high forces the top code, 700mA plus 100mA per step
    next_st.peak_lim = next_st.sync2.peak_limit_strap ? bcl_pkg::PEAK_CODE_STRAP
                       : next_st.cfg.peak_code;

    // Enable combination
    if (st.cfg.en_and) begin
      next_st.en = s.hw_enable & st.cfg.sw_enable;
    end else begin
      next_st.en = s.hw_enable | st.cfg.sw_enable;
    end
    active = st.en && !s.uvlo;

    // Switching clock with optional triangle dither
    if (st.cfg.freq_dither_select) begin
      step = dither_step(st.tri_cnt);
      if (st.tri_down) begin
        if (st.tri_cnt == 13'h0) begin
          next_st.tri_down = 1'b0;
        end else begin
          next_st.tri_cnt = st.tri_cnt - 13'h1;
        end
      end else if (st.tri_cnt >= TRI_TOP) begin
        next_st.tri_down = 1'b1;
      end else begin
        next_st.tri_cnt = st.tri_cnt + 13'h1;
      end
    end else begin
      next_st.tri_cnt = 13'h0;
      next_st.tri_down = 1'b0;
    end
    {tick, next_st.acc} = {1'b0, st.acc} + {1'b0, step};

    // Sequencing
    ss_last = st.cfg.ramp_time_select ? SS_SHORT_LAST : SS_LONG_LAST;
    unique case (st.mode)
      bcl_pkg::BCL_OFF: begin
        if (active) begin
          next_st.mode = bcl_pkg::BCL_SOFTSTART;
          next_st.tmr = 20'h0;
          next_st.ramp = 8'h0;
        end
      end
      bcl_pkg::BCL_SOFTSTART: begin
        if (st.tmr >= ss_last) begin
          next_st.tmr = 20'h0;
          if (st.ramp == bcl_pkg::RAMP_TOP) begin
            next_st.mode = bcl_pkg::BCL_RUN;
          end else begin
            next_st.ramp = st.ramp + 8'h1;
          end
        end else begin
          next_st.tmr = st.tmr + 20'h1;
        end
      end
      bcl_pkg::BCL_RUN: begin
        if (s.in_regulation && s.light_load && st.phase == bcl_pkg::BCL_SW_IDLE) begin
          next_st.mode = bcl_pkg::BCL_STANDBY;
        end
      end
      bcl_pkg::BCL_STANDBY: begin
        if (s.below_99) begin
          next_st.mode = bcl_pkg::BCL_RUN;
        end
      end
      bcl_pkg::BCL_HICCUP: begin
        if (st.tmr >= RETRY_LAST) begin
          if (!s.thermal_shdn) begin
            next_st.mode = bcl_pkg::BCL_SOFTSTART;
            next_st.tmr = 20'h0;
            next_st.ramp = 8'h0;
          end
        end else begin
          next_st.tmr = st.tmr + 20'h1;
        end
      end
      default: begin
        next_st.mode = bcl_pkg::BCL_OFF;
      end
    endcase

    // Power stage sequencing
    switching = st.mode == bcl_pkg::BCL_SOFTSTART || st.mode == bcl_pkg::BCL_RUN;
    start_ok = tick && !(s.below_25 && !s.below_valley);
    on_end = s.pwm_trip || s.peak_trip;
    next_st.dead_cnt = 2'h0;
    unique case (st.phase)
      bcl_pkg::BCL_SW_IDLE: begin
        // Low switch may have opened a cycle ago, so keep the dead time
        if (start_ok) begin
          next_st.phase = bcl_pkg::BCL_SW_DEAD_LH;
        end
      end
      bcl_pkg::BCL_SW_HIGH: begin
        if (on_end) begin
          next_st.phase = bcl_pkg::BCL_SW_DEAD_HL;
          if (s.peak_trip && s.below_25) begin
            next_st.hiccup_cnt = st.hiccup_cnt + 4'h1;
          end else begin
            next_st.hiccup_cnt = 4'h0;
          end
        end
      end
      bcl_pkg::BCL_SW_DEAD_HL: begin
        next_st.dead_cnt = st.dead_cnt + 2'h1;
        if (st.dead_cnt == DEAD_LAST) begin
          next_st.phase = bcl_pkg::BCL_SW_LOW;
        end
      end
      bcl_pkg::BCL_SW_LOW: begin
        if (s.below_zero_cross) begin
          next_st.phase = bcl_pkg::BCL_SW_IDLE;
        end else if (start_ok) begin
          next_st.phase = bcl_pkg::BCL_SW_DEAD_LH;
        end
      end
      bcl_pkg::BCL_SW_DEAD_LH: begin
        next_st.dead_cnt = st.dead_cnt + 2'h1;
        if (st.dead_cnt == DEAD_LAST) begin
          // Valley block also holds back an on-time already queued
          if (s.below_25 && !s.below_valley) begin
            next_st.phase = bcl_pkg::BCL_SW_IDLE;
          end else begin
            next_st.phase = bcl_pkg::BCL_SW_HIGH;
          end
        end
      end
      default: begin
        next_st.phase = bcl_pkg::BCL_SW_IDLE;
      end
    endcase
    if (!s.below_25) begin
      next_st.hiccup_cnt = 4'h0;
    end
    hiccup_trip = s.below_25 && next_st.hiccup_cnt >= bcl_pkg::HICCUP_LIMIT;

    // Faults and disable override the sequence
    if (switching && (hiccup_trip || s.thermal_shdn)) begin
      next_st.mode = bcl_pkg::BCL_HICCUP;
      next_st.tmr = 20'h0;
    end else if (st.mode == bcl_pkg::BCL_STANDBY && s.thermal_shdn) begin
      next_st.mode = bcl_pkg::BCL_HICCUP;
      next_st.tmr = 20'h0;
    end
    if (!active) begin
      next_st.mode = bcl_pkg::BCL_OFF;
    end
    if (!(next_st.mode == bcl_pkg::BCL_SOFTSTART || next_st.mode == bcl_pkg::BCL_RUN)) begin
      next_st.phase = bcl_pkg::BCL_SW_IDLE;
      next_st.hiccup_cnt = 4'h0;
    end
    next_st.hs = next_st.phase == bcl_pkg::BCL_SW_HIGH;
    next_st.ls = next_st.phase == bcl_pkg::BCL_SW_LOW;
    next_st.hiz = next_st.phase == bcl_pkg::BCL_SW_IDLE;
    next_st.standby = next_st.mode == bcl_pkg::BCL_STANDBY;

    // Output good with hysteresis
    if (next_st.mode == bcl_pkg::BCL_OFF || next_st.mode == bcl_pkg::BCL_HICCUP) begin
      next_st.good = 1'b0;
    end else if (s.above_92) begin
      next_st.good = 1'b1;
    end else if (s.below_90) begin
      next_st.good = 1'b0;
    end
    next_st.good_oe = !next_st.good;

    // Internal supply and rail handover
    next_st.bias_to_out = s.fixed_high_vout && s.in_regulation
                          && (next_st.mode == bcl_pkg::BCL_RUN
                              || next_st.mode == bcl_pkg::BCL_STANDBY);
    next_st.bias_ldo = (s.hw_enable || s.interface_rail_valid)
                       && !next_st.bias_to_out;

    // Input mux: ideal-diode selection with hysteresis
    if (!active) begin
      next_st.mux_a_on = 1'b0;
      next_st.mux_b_on = 1'b0;
    end else if (!st.mux_a_on && !st.mux_b_on) begin
      next_st.mux_a_on = !s.mux_b_over_a;
      next_st.mux_b_on = s.mux_b_over_a;
    end else if (st.mux_a_on && s.mux_b_over_a) begin
      next_st.mux_a_on = 1'b0;
      next_st.mux_b_on = 1'b1;
    end else if (st.mux_b_on && s.mux_a_over_b) begin
      next_st.mux_a_on = 1'b1;
      next_st.mux_b_on = 1'b0;
    end
  end

  // ******************************************************************
  // State register
  // ******************************************************************
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      st <= bcl_pkg::ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign AVS_READDATA_OUT = st.rdata;
  assign AVS_WAITREQUEST_OUT = st.wait_req;
  assign HIGH_SIDE_SWITCH_OUT = st.hs;
  assign LOW_SIDE_SWITCH_OUT = st.ls;
  assign SWITCH_NODE_HIZ_OUT = st.hiz;
  assign STANDBY_OUT = st.standby;
  assign PEAK_CURRENT_LIMIT_OUT = st.peak_lim;
  assign RAMP_LEVEL_OUT = st.ramp;
  assign OUTPUT_GOOD_OUT = 1'b0;
  assign OUTPUT_GOOD_OE_OUT = st.good_oe;
  assign BIAS_LDO_ON_OUT = st.bias_ldo;
  assign BIAS_TO_OUTPUT_OUT = st.bias_to_out;
  assign MUX_INPUT_A_ON_OUT = st.mux_a_on;
  assign MUX_INPUT_B_ON_OUT = st.mux_b_on;
endmodule : bcl_ctrl

`default_nettype wire

// >>> test/bcl_ctrl_monitor.sv
// Port assertions of the buck regulator control logic
`timescale 1ns/10ps
`default_nettype none
module bcl_ctrl_monitor (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic AVS_WAITREQUEST_OUT,
  input wire bcl_pkg::bcl_sense_t SENSE_IN,
  input wire logic HIGH_SIDE_SWITCH_OUT,
  input wire logic LOW_SIDE_SWITCH_OUT,
  input wire logic SWITCH_NODE_HIZ_OUT,
  input wire logic STANDBY_OUT,
  input wire logic [1:0] PEAK_CURRENT_LIMIT_OUT,
  input wire logic [7:0] RAMP_LEVEL_OUT,
  input wire logic OUTPUT_GOOD_OE_OUT,
  input wire logic BIAS_LDO_ON_OUT,
  input wire logic BIAS_TO_OUTPUT_OUT,
  input wire logic MUX_INPUT_A_ON_OUT,
  input wire logic MUX_INPUT_B_ON_OUT
);
  // ***
  // Properties
  // ***
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  dead_after_a: assert property ($fell(HIGH_SIDE_SWITCH_OUT) |-> !LOW_SIDE_SWITCH_OUT[*2])
    else $error("low switch on in dead time");
  dead_before_a: assert property ($rose(HIGH_SIDE_SWITCH_OUT) |->
    $past(LOW_SIDE_SWITCH_OUT) == 1'b0 && $past(LOW_SIDE_SWITCH_OUT, 2) == 1'b0)
    else $error("high switch on without dead time");
  bus_answer_a: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
    |=> !AVS_WAITREQUEST_OUT) else $error("bus answer late");
  bus_single_a: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
    else $error("wait low too long");
  strap_fixed_a: assert property (SENSE_IN.peak_limit_strap[*4] |-> PEAK_CURRENT_LIMIT_OUT == 2'h3)
    else $error("strap limit wrong");
  standby_hiz_a: assert property (STANDBY_OUT |->
    SWITCH_NODE_HIZ_OUT && !HIGH_SIDE_SWITCH_OUT && !LOW_SIDE_SWITCH_OUT)
    else $error("switching in standby");
  good_rise_a: assert property ($fell(OUTPUT_GOOD_OE_OUT) |->
    $past(SENSE_IN.above_92, 3) || $past(SENSE_IN.above_92, 4)) else $error("good released early");
  ramp_step_a: assert property ($changed(RAMP_LEVEL_OUT) && RAMP_LEVEL_OUT != 8'h0 |->
    RAMP_LEVEL_OUT == 8'($past(RAMP_LEVEL_OUT) + 8'h1) ##1 $stable(RAMP_LEVEL_OUT)[*4])
    else $error("ramp step wrong");
  valley_hold_a: assert property ((SENSE_IN.below_25 && !SENSE_IN.below_valley)[*3]
    |=> !$rose(HIGH_SIDE_SWITCH_OUT)) else $error("on-time above valley");
  mux_excl_a: assert property (!(MUX_INPUT_A_ON_OUT && MUX_INPUT_B_ON_OUT))
    else $error("both mux inputs on");
  bias_rail_a: assert property ((SENSE_IN.interface_rail_valid && !SENSE_IN.fixed_high_vout)[*4]
    |-> BIAS_LDO_ON_OUT) else $error("internal supply off");
  bias_excl_a: assert property (!(BIAS_LDO_ON_OUT && BIAS_TO_OUTPUT_OUT))
    else $error("supply and output rail both on");
  cover property ($rose(STANDBY_OUT));
  cover property (RAMP_LEVEL_OUT == 8'hff);
  cover property ($fell(OUTPUT_GOOD_OE_OUT));
endmodule : bcl_ctrl_monitor
bind bcl_ctrl bcl_ctrl_monitor mon (.*);
`default_nettype wire

// >>> test/bcl_stage_model.sv
// Power stage model answering the gates with current comparator levels
`timescale 1ns/10ps
`default_nettype none
module bcl_stage_model (
  input wire logic clk_in,
  input wire logic hs_in,
  input wire logic ls_in,
  input wire logic short_in,
  input wire logic [4:0] on_len_in,
  output logic pwm_trip_out,
  output logic peak_trip_out,
  output logic zero_cross_out,
  output logic valley_out
);
  // ***
  // Inductor current
  // ***
  int unsigned on_cnt = 0;
  int unsigned off_cnt = 0;
  always @(posedge clk_in) begin
    on_cnt <= hs_in ? on_cnt + 1 : 0;
    off_cnt <= hs_in ? 0 : off_cnt + 1;
  end
  // A short reaches the peak limit two cycles into the on-time and drains slowly
  assign pwm_trip_out = hs_in && !short_in && on_cnt >= on_len_in;
  assign peak_trip_out = hs_in && short_in && on_cnt >= 2;
  assign zero_cross_out = ls_in && off_cnt >= 8;
  assign valley_out = !short_in || off_cnt >= 30;
endmodule : bcl_stage_model
`default_nettype wire

// >>> test/bcl_ctrl_test.sv
// Self-checking bench for the buck regulator control logic
`timescale 1ns/10ps
`default_nettype none
module bcl_ctrl_test;
  // ***
  // Harness and reference model
  // ***
  localparam int SSL = 2560;
  localparam int SSS = 1280;
  localparam int RTY = 500;
  logic clk, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, shrt = 1'b0, hs_q = 1'b0;
  logic wreq, hs, ls, hiz, stby, good, oe, ldo, b2o, mxa, mxb, pwm, pk, zx, vl;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [1:0] peak;
  logic [7:0] ramp;
  logic [4:0] on_len = 5'h4;
  logic [15:0] rnd = 16'h74b2;
  bcl_pkg::bcl_sense_t sv, sense;
  int errors = 0, n_checks = 0, rises = 0, gmin = 99, gmax = 0, gap = 0, n = 0;
  int m_sw = 0, m_and = 0, m_rt = 0, m_dt = 0, m_pk = 0;
  bcl_ctrl #(.SS_LONG_CYCLES(SSL), .SS_SHORT_CYCLES(SSS), .RETRY_CYCLES(RTY),
    .DITHER_CYCLES(200)) dut (.CLOCK_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'h1),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq), .SENSE_IN(sense),
    .HIGH_SIDE_SWITCH_OUT(hs), .LOW_SIDE_SWITCH_OUT(ls), .SWITCH_NODE_HIZ_OUT(hiz),
    .STANDBY_OUT(stby), .PEAK_CURRENT_LIMIT_OUT(peak), .RAMP_LEVEL_OUT(ramp),
    .OUTPUT_GOOD_OUT(good), .OUTPUT_GOOD_OE_OUT(oe), .BIAS_LDO_ON_OUT(ldo),
    .BIAS_TO_OUTPUT_OUT(b2o), .MUX_INPUT_A_ON_OUT(mxa), .MUX_INPUT_B_ON_OUT(mxb));
  bcl_stage_model stage (.clk_in(clk), .hs_in(hs), .ls_in(ls), .short_in(shrt),
    .on_len_in(on_len), .pwm_trip_out(pwm), .peak_trip_out(pk), .zero_cross_out(zx),
    .valley_out(vl));
  always_comb begin
    sense = sv;
    sense.pwm_trip = pwm;
    sense.peak_trip = pk;
    sense.below_zero_cross = zx;
    sense.below_valley = vl;
    sense.output_good_pin = !oe;
  end
  always @(posedge clk) begin
    hs_q <= hs;
    gap <= gap + 1;
    if (hs && !hs_q) begin
      rises <= rises + 1;
      gap <= 1;
      if (gap < gmin) gmin <= gap;
      if (gap > gmax) gmax <= gap;
    end
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask : chk
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask : cyc
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr_ctrl(input logic [31:0] v);
    bus(1'b1, bcl_pkg::REG_CTRL, v);
    m_sw = v[0];
    m_and = v[1];
    m_rt = v[2];
    m_dt = v[3];
    if (!sv.peak_limit_strap) m_pk = v[5:4];
    bus(1'b0, bcl_pkg::REG_CTRL, 32'h0);
    chk("ctrl", q, 32'(m_sw + 2 * m_and + 4 * m_rt + 8 * m_dt + 16 * m_pk));
  endtask : wr_ctrl
  task automatic till_ramp(input logic [7:0] v);
    n = 0;
    while (ramp !== v && n < 9000) begin
      @(posedge clk);
      n++;
    end
  endtask : till_ramp
  task automatic clr();
    @(negedge clk);
    rises = 0;
    gmin = 99;
    gmax = 0;
    @(posedge clk);
  endtask : clr
  initial begin
    cyc(25000);
    errors++;
    finish_test();
  end
  // ***
  // Scenarios
  // ***
  initial begin
    sv = '0;
    sv.interface_rail_valid = 1'b1;
    cyc(3);
    rst_n <= 1'b1;
    cyc(1);
    bus(1'b0, bcl_pkg::REG_CTRL, 32'h0);
    chk("ctrl reset", q, 0);
    chk("peak reset", peak, 0);
    chk("good data", good, 0);
    bus(1'b1, 4'h8, 32'hffffffff);
    bus(1'b0, 4'h8, 32'h0);
    chk("unmapped", q, 0);
    for (int i = 0; i < 8; i++) begin
      sv.hw_enable <= i[2];
      wr_ctrl(32'(i[1:0]));
      cyc(6);
      bus(1'b0, bcl_pkg::REG_STATUS, 32'h0);
      n = m_and ? (i[2] & m_sw) : (i[2] | m_sw);
      chk("enable", q[bcl_pkg::STAT_EN], n);
      chk("mux a", mxa, n);
    end
    sv.mux_b_over_a <= 1'b1;
    cyc(5);
    sv.mux_b_over_a <= 1'b0;
    cyc(5);
    chk("mux hold", {mxa, mxb}, 2'b01);
    for (int c = 3; c >= 0; c--) begin
      wr_ctrl(32'(c) << 4);
      chk("peak code", peak, c);
    end
    sv.peak_limit_strap <= 1'b1;
    cyc(4);
    wr_ctrl(32'h20);
    chk("strap", peak, 3);
    sv.peak_limit_strap <= 1'b0;
    cyc(4);
    chk("strap off", peak, 0);
    for (int j = 0; j < 2; j++) begin
      wr_ctrl(32'h3d);
      if (j == 0) sv.uvlo <= 1'b1;
      else sv.interface_rail_valid <= 1'b0;
      cyc(4);
      sv.uvlo <= 1'b0;
      sv.interface_rail_valid <= 1'b1;
      cyc(3);
      bus(1'b0, bcl_pkg::REG_CTRL, 32'h0);
      chk("cfg reset", q, 0);
    end
    m_sw = 0;
    m_rt = 0;
    m_dt = 0;
    m_pk = 0;
    for (int k = 0; k < 2; k++) begin
      sv.hw_enable <= 1'b0;
      wr_ctrl(32'(k) << 2);
      cyc(6);
      sv.hw_enable <= 1'b1;
      till_ramp(8'h01);
      till_ramp(8'hff);
      chk("ramp time", n, 254 * ((k ? SSS : SSL) / 256));
    end
    for (int k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      on_len <= 5'(1 + rnd[2:0]);
      wr_ctrl(32'(k) << 3);
      clr();
      cyc(600);
      chk("rate", rises >= 23 && rises <= 25, 1);
      chk("spread", (gmax - gmin >= 2) == k, 1);
    end
    sv.above_92 <= 1'b1;
    cyc(5);
    chk("good rise", oe, 0);
    sv.above_92 <= 1'b0;
    sv.below_90 <= 1'b1;
    cyc(5);
    chk("good fall", oe, 1);
    sv.below_90 <= 1'b0;
    sv.above_92 <= 1'b1;
    sv.in_regulation <= 1'b1;
    sv.light_load <= 1'b1;
    sv.fixed_high_vout <= 1'b1;
    cyc(60);
    chk("standby", {stby, hiz, b2o, ldo, oe}, 5'b11100);
    sv.below_99 <= 1'b1;
    sv.light_load <= 1'b0;
    clr();
    cyc(40);
    chk("wake", {stby, rises != 0}, 2'b01);
    sv.below_99 <= 1'b0;
    sv.in_regulation <= 1'b0;
    n = 0;
    while (hs !== 1'b1 && n < 99) begin
      @(posedge clk);
      n++;
    end
    while (hs !== 1'b0 && n < 99) begin
      @(posedge clk);
      n++;
    end
    sv.below_25 <= 1'b1;
    shrt <= 1'b1;
    clr();
    n = 0;
    do begin
      bus(1'b0, bcl_pkg::REG_STATUS, 32'h0);
      n++;
    end while (q[2:0] !== 3'h4 && n < 2000);
    chk("hiccup count", rises, 15);
    chk("retry good", oe, 1);
    shrt <= 1'b0;
    sv.below_25 <= 1'b0;
    till_ramp(8'h01);
    chk("retry time", n > RTY && n < RTY + 15, 1);
    finish_test();
  end
endmodule : bcl_ctrl_test
`default_nettype wire
